// [crf_pkg.sv]
// Purpose: Shared constants and types for the processor register set and flags
// Assumes: One 40 MHz clock, register port with one-cycle read latency
// Notes: Register indices below are byte-free word indices of the plain port
package crf_pkg;

  // ----------------------------------------------------------------
  // Register indices on the plain port
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_DATA0 = 4'h0;
  localparam logic [3:0] IDX_DATA1 = 4'h1;
  localparam logic [3:0] IDX_DATA2 = 4'h2;
  localparam logic [3:0] IDX_DATA3 = 4'h3;
  localparam logic [3:0] IDX_ADDR0 = 4'h4;
  localparam logic [3:0] IDX_ADDR1 = 4'h5;
  localparam logic [3:0] IDX_FRAME = 4'h6;
  localparam logic [3:0] IDX_STATIC = 4'h7;
  localparam logic [3:0] IDX_VECTOR = 4'h8;
  localparam logic [3:0] IDX_PC = 4'h9;
  localparam logic [3:0] IDX_USP = 4'hA;
  localparam logic [3:0] IDX_ISP = 4'hB;
  localparam logic [3:0] IDX_FLAGS = 4'hC;
  localparam logic [3:0] IDX_ACTIVE_SP = 4'hD;

  // ----------------------------------------------------------------
  // Flag register field positions
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  localparam int FLG_IPL_LO = 8;
  localparam int FLG_RSV = 11;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int WIDE_W = 20;
  localparam int FLAG_W = 11;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [19:0] RST_WIDE = 20'h00000;
  localparam logic [10:0] RST_FLAGS = 11'h000;
  localparam logic [4:0] SWI_MAX_CLR_U = 5'h1F;

  // ALU result bundle from the execution pipeline
  typedef struct packed {
    logic valid;
    logic carry;
    logic zero;
    logic sign;
    logic ovf;
  } crf_alu_t;

  // Interrupt acknowledge bundle
  typedef struct packed {
    logic hw_ack;
    logic sw_ack;
    logic [5:0] sw_num;
  } crf_ack_t;

endpackage

// [crf_regs.sv]
// Purpose: Programmer-visible register set and processor flag register
// Assumes: Pipeline writes through the plain port, alu and ack strobes one cycle
// Notes: All outputs registered; read data appears the cycle after read and holds until the next read
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module crf_regs
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Byte access to the first two data registers, pair access to data and address registers
  input wire logic [1:0] byte_sel,
  input wire logic byte_wr,
  input wire logic [7:0] byte_wdata,
  input wire logic [1:0] pair_sel,
  input wire logic pair_wr,
  // Pipeline status inputs
  input wire crf_pkg::crf_alu_t alu,
  input wire crf_pkg::crf_ack_t ack,
  input wire logic pc_load,
  input wire logic [19:0] pc_next,
  // Interrupt request to qualify
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  // Observed state
  output logic [31:0] data_pair_low_32,
  output logic [31:0] data_pair_high_32,
  output logic [31:0] addr_pair_32,
  output logic [15:0] active_sp,
  output logic [19:0] program_counter,
  output logic [10:0] flags,
  output logic irq_accept
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Release through two flops to avoid reset recovery races
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] data_reg [4]; // General data registers
  logic [15:0] addr_reg_0; // Pointer register low
  logic [15:0] addr_reg_1; // Pointer register high
  logic [15:0] frame_base_register;
  logic [15:0] static_base_register;
  logic [19:0] vector_table_base;
  logic [15:0] user_stack_pointer;
  logic [15:0] interrupt_stack_pointer;
  logic [10:0] processor_flag_register;
  logic [19:0] pc;

  // Word write strobe for an index
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx, input logic w);
    hit = w && (a == idx);
  endfunction

  // Software interrupt that forces the interrupt stack
  function automatic logic sw_clears_u(input crf_pkg::crf_ack_t k);
    sw_clears_u = k.sw_ack && (k.sw_num[5] == 1'b0) && (k.sw_num[4:0] <= crf_pkg::SWI_MAX_CLR_U);
  endfunction

  // ----------------------------------------------------------------
  // Data registers, word, byte and pair writes
  // ----------------------------------------------------------------
  // Word writes win over byte writes in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        data_reg[i] <= crf_pkg::RST_WORD;
    end
    else
    begin
      // Byte halves only exist on the first two registers
      if (byte_wr)
      begin
        if (byte_sel[1])
          data_reg[byte_sel[0]][15:8] <= byte_wdata;
        else
          data_reg[byte_sel[0]][7:0] <= byte_wdata;
      end
      // Pair writes: low word to first/second, high word to third/fourth
      if (pair_wr)
      begin
        if (pair_sel == 2'h0)
        begin
          data_reg[0] <= wdata[15:0];
          data_reg[2] <= wdata[31:16];
        end
        else if (pair_sel == 2'h1)
        begin
          data_reg[1] <= wdata[15:0];
          data_reg[3] <= wdata[31:16];
        end
      end
      // Plain 16-bit writes
      for (int i = 0; i < 4; i++)
        if (hit(addr, 4'(i), wr))
          data_reg[i] <= wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Address and base registers
  // ----------------------------------------------------------------
  // Address pair write uses the second register as upper half
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_reg_0 <= crf_pkg::RST_WORD;
      addr_reg_1 <= crf_pkg::RST_WORD;
      frame_base_register <= crf_pkg::RST_WORD;
      static_base_register <= crf_pkg::RST_WORD;
      vector_table_base <= crf_pkg::RST_WIDE;
    end
    else
    begin
      if (pair_wr && pair_sel == 2'h2)
      begin
        addr_reg_0 <= wdata[15:0];
        addr_reg_1 <= wdata[31:16];
      end
      if (hit(addr, crf_pkg::IDX_ADDR0, wr))
        addr_reg_0 <= wdata[15:0];
      if (hit(addr, crf_pkg::IDX_ADDR1, wr))
        addr_reg_1 <= wdata[15:0];
      if (hit(addr, crf_pkg::IDX_FRAME, wr))
        frame_base_register <= wdata[15:0];
      if (hit(addr, crf_pkg::IDX_STATIC, wr))
        static_base_register <= wdata[15:0];
      if (hit(addr, crf_pkg::IDX_VECTOR, wr))
        vector_table_base <= wdata[19:0];
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack pointers
  // ----------------------------------------------------------------
  // Pipeline load takes priority over a port write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pc <= crf_pkg::RST_WIDE;
    else if (pc_load)
      pc <= pc_next;
    else if (hit(addr, crf_pkg::IDX_PC, wr))
      pc <= wdata[19:0];
  end

  // Active pointer index writes the pointer picked by the stack flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      user_stack_pointer <= crf_pkg::RST_WORD;
      interrupt_stack_pointer <= crf_pkg::RST_WORD;
    end
    else
    begin
      if (hit(addr, crf_pkg::IDX_USP, wr) ||
          (hit(addr, crf_pkg::IDX_ACTIVE_SP, wr) && processor_flag_register[crf_pkg::FLG_U]))
        user_stack_pointer <= wdata[15:0];
      if (hit(addr, crf_pkg::IDX_ISP, wr) ||
          (hit(addr, crf_pkg::IDX_ACTIVE_SP, wr) && !processor_flag_register[crf_pkg::FLG_U]))
        interrupt_stack_pointer <= wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  // Hardware events override a same-cycle software write of the flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      processor_flag_register <= crf_pkg::RST_FLAGS;
    else
    begin
      // Software write; debug bit is the caller's to keep at zero
      if (hit(addr, crf_pkg::IDX_FLAGS, wr))
        processor_flag_register <= wdata[10:0];
      // Arithmetic status from the unit
      if (alu.valid)
      begin
        processor_flag_register[crf_pkg::FLG_C] <= alu.carry;
        processor_flag_register[crf_pkg::FLG_Z] <= alu.zero;
        processor_flag_register[crf_pkg::FLG_S] <= alu.sign;
        processor_flag_register[crf_pkg::FLG_O] <= alu.ovf;
      end
      // Any acknowledge masks further maskable requests
      if (ack.hw_ack || ack.sw_ack)
        processor_flag_register[crf_pkg::FLG_I] <= 1'b0;
      // Back to the interrupt stack
      if (ack.hw_ack || sw_clears_u(ack))
        processor_flag_register[crf_pkg::FLG_U] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Mirrors of live state, one flop behind so outputs stay registered
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_pair_low_32 <= 32'h0000_0000;
      data_pair_high_32 <= 32'h0000_0000;
      addr_pair_32 <= 32'h0000_0000;
      active_sp <= crf_pkg::RST_WORD;
      program_counter <= crf_pkg::RST_WIDE;
      flags <= crf_pkg::RST_FLAGS;
      irq_accept <= 1'b0;
    end
    else
    begin
      data_pair_low_32 <= {data_reg[2], data_reg[0]};
      data_pair_high_32 <= {data_reg[3], data_reg[1]};
      addr_pair_32 <= {addr_reg_1, addr_reg_0};
      active_sp <= processor_flag_register[crf_pkg::FLG_U] ?
                   user_stack_pointer : interrupt_stack_pointer;
      program_counter <= pc;
      flags <= processor_flag_register;
      // Strictly above current level and only while enabled
      irq_accept <= irq_req && processor_flag_register[crf_pkg::FLG_I] &&
                    (irq_level > processor_flag_register[crf_pkg::FLG_RSV-1 -: 3]);
    end
  end

  // Read port: reserved flag bit reads zero, a legal undefined value
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (addr)
        crf_pkg::IDX_DATA0: rdata <= {16'h0000, data_reg[0]};
        crf_pkg::IDX_DATA1: rdata <= {16'h0000, data_reg[1]};
        crf_pkg::IDX_DATA2: rdata <= {16'h0000, data_reg[2]};
        crf_pkg::IDX_DATA3: rdata <= {16'h0000, data_reg[3]};
        crf_pkg::IDX_ADDR0: rdata <= {16'h0000, addr_reg_0};
        crf_pkg::IDX_ADDR1: rdata <= {16'h0000, addr_reg_1};
        crf_pkg::IDX_FRAME: rdata <= {16'h0000, frame_base_register};
        crf_pkg::IDX_STATIC: rdata <= {16'h0000, static_base_register};
        crf_pkg::IDX_VECTOR: rdata <= {12'h000, vector_table_base};
        crf_pkg::IDX_PC: rdata <= {12'h000, pc};
        crf_pkg::IDX_USP: rdata <= {16'h0000, user_stack_pointer};
        crf_pkg::IDX_ISP: rdata <= {16'h0000, interrupt_stack_pointer};
        crf_pkg::IDX_FLAGS: rdata <= {21'h000000, processor_flag_register};
        crf_pkg::IDX_ACTIVE_SP: rdata <= {16'h0000, processor_flag_register[crf_pkg::FLG_U] ?
                                 user_stack_pointer : interrupt_stack_pointer};
        default: rdata <= 32'h0000_0000; // Unmapped index
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hw_ack_u;
    @(posedge clock) disable iff (!rst_n)
    ack.hw_ack |=> !processor_flag_register[crf_pkg::FLG_U];
  endproperty
  a_hw_ack_u: assert property (p_hw_ack_u) else $error("stack flag not cleared");

  property p_ack_i;
    @(posedge clock) disable iff (!rst_n)
    (ack.hw_ack || ack.sw_ack) |=> !processor_flag_register[crf_pkg::FLG_I];
  endproperty
  a_ack_i: assert property (p_ack_i) else $error("enable flag not cleared");

  property p_zero;
    @(posedge clock) disable iff (!rst_n)
    (alu.valid && !ack.hw_ack) |=> processor_flag_register[crf_pkg::FLG_Z] == $past(alu.zero);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_carry;
    @(posedge clock) disable iff (!rst_n)
    alu.valid |=> processor_flag_register[crf_pkg::FLG_C] == $past(alu.carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  property p_accept;
    @(posedge clock) disable iff (!rst_n)
    (irq_req && !processor_flag_register[crf_pkg::FLG_I]) |=> !irq_accept;
  endproperty
  a_accept: assert property (p_accept) else $error("masked request accepted");

  property p_sp;
    @(posedge clock) disable iff (!rst_n)
    ##1 active_sp == ($past(processor_flag_register[crf_pkg::FLG_U]) ?
        $past(user_stack_pointer) : $past(interrupt_stack_pointer));
  endproperty
  a_sp: assert property (p_sp) else $error("wrong stack pointer");

  property p_pair;
    @(posedge clock) disable iff (!rst_n)
    ##2 addr_pair_32 == {$past(addr_reg_1), $past(addr_reg_0)};
  endproperty
  a_pair: assert property (p_pair) else $error("address pair wrong");

  property p_pc;
    @(posedge clock) disable iff (!rst_n)
    pc_load |=> ##1 program_counter == $past(pc_next, 2);
  endproperty
  a_pc: assert property (p_pc) else $error("counter not loaded");

  c_hw_ack: cover property (@(posedge clock) disable iff (!rst_n) ack.hw_ack);
  c_accept: cover property (@(posedge clock) disable iff (!rst_n) irq_accept);
  c_rd: cover property (@(posedge clock) disable iff (!rst_n) rd && addr == crf_pkg::IDX_FLAGS);

endmodule

// [crf_pipe_model.sv]
// Purpose: Model of the execution pipeline and interrupt acknowledge side
// Assumes: Every pulse is launched just after a rising edge and lasts one cycle
// Notes: Behavioural; each task owns its own signals, so tasks may overlap
`timescale 1ns/1ps
module crf_pipe_model
(
  // Clock
  input wire logic clock,
  // Status towards the register set
  output crf_pkg::crf_alu_t alu,
  output crf_pkg::crf_ack_t ack,
  output logic pc_load,
  output logic [19:0] pc_next,
  // Interrupt request
  output logic irq_req,
  output logic [2:0] irq_level
);
  // ----------------------------------------------------------------
  // Idle levels at time zero
  // ----------------------------------------------------------------
  initial
  begin
    alu = '0;
    ack = '0;
    pc_load = 1'b0;
    pc_next = 20'h00000;
    irq_req = 1'b0;
    irq_level = 3'h0;
  end

  // One result, pattern is {ovf, sign, zero, carry}
  task automatic alu_op(input logic [3:0] f);
    @(posedge clock);
    alu <= {1'b1, f[0], f[1], f[2], f[3]};
    @(posedge clock);
    alu <= '0;
  endtask

  // One acknowledge; number inverted afterwards so stale values never match
  task automatic acknowledge(input logic hw, input logic sw, input logic [5:0] num);
    @(posedge clock);
    ack <= {hw, sw, num};
    @(posedge clock);
    ack <= {2'b00, ~num};
  endtask

  // Jump target, scrambled once the strobe drops
  task automatic load_pc(input logic [19:0] v);
    @(posedge clock);
    pc_load <= 1'b1;
    pc_next <= v;
    @(posedge clock);
    pc_load <= 1'b0;
    pc_next <= ~v;
  endtask

  // Request is a level, held until changed
  task automatic set_irq(input logic r, input logic [2:0] l);
    @(posedge clock);
    irq_req <= r;
    irq_level <= l;
  endtask
endmodule

// [crf_regs_bench.sv]
// Purpose: Self-checking bench for the register set and flag register
// Assumes: Port master with one-cycle read latency, pipeline model beside it
// Notes: State outputs lag a write by two edges, so checks wait two edges
`timescale 1ns/1ps
module crf_regs_bench;
  // Clock, reset and port master
  logic clock, nrst, wr, rd, byte_wr, pair_wr;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, data_pair_low_32, data_pair_high_32, addr_pair_32;
  logic [1:0] byte_sel, pair_sel;
  logic [7:0] byte_wdata;
  // Pipeline side and observed state
  crf_pkg::crf_alu_t alu;
  crf_pkg::crf_ack_t ack;
  logic pc_load, irq_req, irq_accept;
  logic [19:0] pc_next, program_counter;
  logic [2:0] irq_level;
  logic [15:0] active_sp;
  logic [10:0] flags;
  int failures = 0;
  int checked = 0;
  logic [31:0] vals [12];

  crf_regs uut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .byte_sel(byte_sel), .byte_wr(byte_wr), .byte_wdata(byte_wdata),
    .pair_sel(pair_sel), .pair_wr(pair_wr), .alu(alu), .ack(ack), .pc_load(pc_load),
    .pc_next(pc_next), .irq_req(irq_req), .irq_level(irq_level),
    .data_pair_low_32(data_pair_low_32), .data_pair_high_32(data_pair_high_32),
    .addr_pair_32(addr_pair_32), .active_sp(active_sp), .program_counter(program_counter),
    .flags(flags), .irq_accept(irq_accept));
  crf_pipe_model pipe (.clock(clock), .alu(alu), .ack(ack), .pc_load(pc_load),
    .pc_next(pc_next), .irq_req(irq_req), .irq_level(irq_level));

  // ----------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Word write: one strobe cycle
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Word read: data sampled in the cycle after the strobe only
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Let the state land and its mirror follow
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Flag word with the debug bit left at zero
  function automatic logic [31:0] flagword(input logic u, input logic ie, input logic [2:0] l);
    flagword = 32'h0000_0000;
    flagword[crf_pkg::FLG_U] = u;
    flagword[crf_pkg::FLG_I] = ie;
    flagword[crf_pkg::FLG_IPL_LO +: 3] = l;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    for (int i = 0; i < 16; i++)
    begin
      rd_reg(4'(i), d);
      chk(d, 32'h0000_0000);
    end
    chk({21'h0, flags}, {21'h0, crf_pkg::RST_FLAGS});
    $display("t_reset done");
  endtask

  // Every word up to the interrupt pointer written first, then read, so aliasing shows up
  task automatic t_words;
    logic [31:0] d;
    for (int i = 0; i < 12; i++)
    begin
      vals[i] = 32'hF0A0_5000 + 32'(i) * 32'h0001_1111;
      if (i != 12'(crf_pkg::IDX_FLAGS)) wr_reg(4'(i), vals[i]);
    end
    wr_reg(4'hE, 32'hFFFF_FFFF);
    for (int i = 0; i < 12; i++)
    begin
      rd_reg(4'(i), d);
      chk(d, vals[i] & ((i == 8 || i == 9) ? 32'h000F_FFFF :
        32'h0000_FFFF));
    end
    rd_reg(4'hE, d);
    chk(d, 32'h0000_0000);
    rd_reg(crf_pkg::IDX_ACTIVE_SP, d);
    chk(d, vals[11] & 32'h0000_FFFF);
    $display("t_words done");
  endtask

  // Byte writes leave the other half untouched
  task automatic t_bytes;
    logic [31:0] d;
    @(posedge clock);
    byte_sel <= 2'b00;
    byte_wdata <= 8'h5A;
    byte_wr <= 1'b1;
    @(posedge clock);
    byte_sel <= 2'b11;
    byte_wdata <= 8'hC3;
    @(posedge clock);
    byte_wr <= 1'b0;
    rd_reg(crf_pkg::IDX_DATA0, d);
    chk(d, {16'h0, vals[0][15:8], 8'h5A});
    rd_reg(crf_pkg::IDX_DATA1, d);
    chk(d, {16'h0, 8'hC3, vals[1][7:0]});
    $display("t_bytes done");
  endtask

  task automatic t_pairs;
    logic [31:0] d, pv, got;
    logic [3:0] lo, hi;
    for (int p = 0; p < 3; p++)
    begin
      pv = 32'h1357_9BDF ^ (32'(p) << 20);
      lo = (p == 0) ? 4'h0 : (p == 1) ? 4'h1 : 4'h4;
      hi = lo + 4'h2 - ((p == 2) ? 4'h1 : 4'h0);
      @(posedge clock);
      pair_sel <= 2'(p);
      wdata <= pv;
      pair_wr <= 1'b1;
      @(posedge clock);
      pair_wr <= 1'b0;
      settle();
      got = (p == 0) ? data_pair_low_32 : (p == 1) ? data_pair_high_32 : addr_pair_32;
      chk(got, pv);
      rd_reg(lo, d);
      chk(d, {16'h0, pv[15:0]});
      rd_reg(hi, d);
      chk(d, {16'h0, pv[31:16]});
    end
    $display("t_pairs done");
  endtask

  task automatic t_flags;
    logic [31:0] fw, d;
    for (int k = 0; k < 5; k++)
    begin
      pipe.alu_op(4'(k == 4 ? 0 : 1 << k));
      settle();
      chk({28'h0, flags[crf_pkg::FLG_O], flags[crf_pkg::FLG_S], flags[crf_pkg::FLG_Z],
        flags[crf_pkg::FLG_C]}, 32'(k == 4 ? 0 : 1 << k));
    end
    fw = flagword(1'b1, 1'b1, 3'h5) | 32'hFFFF_F800;
    fw[crf_pkg::FLG_B] = 1'b1;
    fw[crf_pkg::FLG_C] = 1'b1;
    wr_reg(crf_pkg::IDX_FLAGS, fw);
    rd_reg(crf_pkg::IDX_FLAGS, d);
    chk(d, fw & 32'h0000_07FF);
    chk({21'h0, flags}, fw & 32'h0000_07FF);
    $display("t_flags done");
  endtask

  task automatic t_ack;
    logic [2:0] hw = 3'b100;
    // Stack flag expected after each acknowledge: only number 32 keeps it
    logic [2:0] u = 3'b001;
    logic [5:0] num [3] = '{6'h00, 6'h1F, 6'h20};
    logic [31:0] d;
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(crf_pkg::IDX_FLAGS, flagword(1'b1, 1'b1, 3'h0));
      settle();
      chk({16'h0, active_sp}, vals[10] & 32'h0000_FFFF);
      pipe.acknowledge(hw[2 - k], ~hw[2 - k], num[k]);
      settle();
      chk({30'h0, flags[crf_pkg::FLG_U], flags[crf_pkg::FLG_I]},
        {30'h0, u[2 - k], 1'b0});
      chk({16'h0, active_sp}, vals[u[2 - k] ? 10 : 11] & 32'h0000_FFFF);
    end
    fork
      wr_reg(crf_pkg::IDX_FLAGS, flagword(1'b1, 1'b1, 3'h0));
      pipe.acknowledge(1'b1, 1'b0, 6'h00);
    join
    settle();
    chk({30'h0, flags[crf_pkg::FLG_U], flags[crf_pkg::FLG_I]}, 32'h0);
    // Stack flag now clear, so the active index must reach the interrupt pointer
    wr_reg(crf_pkg::IDX_ACTIVE_SP, 32'h0000_2468);
    rd_reg(crf_pkg::IDX_ISP, d);
    chk(d, 32'h0000_2468);
    $display("t_ack done");
  endtask

  // Every level against every priority, then the two gates
  task automatic t_irq;
    for (int p = 0; p < 8; p++)
    begin
      wr_reg(crf_pkg::IDX_FLAGS, flagword(1'b0, 1'b1, 3'(p)));
      for (int lv = 0; lv < 8; lv++)
      begin
        pipe.set_irq(1'b1, 3'(lv));
        settle();
        chk({31'h0, irq_accept}, 32'(lv > p));
      end
    end
    wr_reg(crf_pkg::IDX_FLAGS, flagword(1'b0, 1'b0, 3'h0));
    settle();
    chk({31'h0, irq_accept}, 32'h0);
    wr_reg(crf_pkg::IDX_FLAGS, flagword(1'b0, 1'b1, 3'h0));
    pipe.set_irq(1'b0, 3'h7);
    settle();
    chk({31'h0, irq_accept}, 32'h0);
    $display("t_irq done");
  endtask

  // Pipeline load, and its priority over a port write in the same cycle
  task automatic t_pc;
    logic [31:0] d;
    pipe.load_pc(20'hABCDE);
    settle();
    chk({12'h0, program_counter}, 32'h000A_BCDE);
    fork
      wr_reg(crf_pkg::IDX_PC, 32'h0001_2345);
      pipe.load_pc(20'h54321);
    join
    settle();
    chk({12'h0, program_counter}, 32'h0005_4321);
    rd_reg(crf_pkg::IDX_PC, d);
    chk(d, 32'h0005_4321);
    $display("t_pc done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    {nrst, wr, rd, byte_wr, pair_wr, addr, byte_sel, pair_sel, byte_wdata} = '0;
    wdata = 32'h0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_words();
    t_bytes();
    t_pairs();
    t_flags();
    t_ack();
    t_irq();
    t_pc();
    print_verdict();
  end

  // Whole run needs about four hundred cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    print_verdict();
  end
endmodule
